// ==== hw/csr_pkg.sv ====
/*
  package for the socket status register bank: offsets, field positions,
  reset values and timing counts.
  assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package csr_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OFS_EVENT     = 4'h0;
  localparam logic [3:0]  OFS_MASK      = 4'h4;
  localparam logic [3:0]  OFS_STATE     = 4'h8;
  localparam logic [3:0]  OFS_FORCE     = 4'hc;
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  // bit positions
  localparam int          B_STSCHG      = 0;
  localparam int          B_CD1         = 1;
  localparam int          B_CD2         = 2;
  localparam int          B_PWR         = 3;
  localparam int          B_C16         = 4;
  localparam int          B_CBUS        = 5;
  localparam int          B_CINT        = 6;
  localparam int          B_NOTCARD     = 7;
  localparam int          B_DLOST       = 8;
  localparam int          B_BADV        = 9;
  localparam int          B_CV_LO       = 10;
  localparam int          B_RETEST      = 14;
  localparam int          B_SYSV_LO     = 28;
  localparam logic [3:0]  SYSV_RESET    = 4'h3;
  localparam logic [3:0]  EVENT_USED    = 4'hf;
  localparam int          PWR_DONE_CYC  = 256;
  // power-up settle time, ns
  localparam int          PWR_UP_NS     = 1000;
  localparam int          CLK_NS        = 8;
  localparam int          PWR_UP_CYC    = (PWR_UP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000;
  typedef enum logic [1:0] {CSR_IDLE, CSR_ACK} csr_bus_e;
  typedef enum logic [2:0] {CSR_P_OFF, CSR_P_RAMP, CSR_P_WAIT, CSR_P_ON} csr_pwr_e;
endpackage

// ==== hw/csr_socket_status.sv ====
/*
  socket status register bank: interrupt mask, live socket state and
  write-only event force register, plus card detect and power sequencing.
  assumes socket pins are asynchronous; all but pin_card_irq are synchronised here; the event
  latch is also held in this block and is driven out of it on event_latch.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Function
// - mask bit 0 enables status-change interrupt
// - mask bits 1,2 enable card-detect change interrupts
// - power-complete interrupt 256 clocks after power-up
// - card removal interrupts if mask bit 1 or 2 is set, then clears whole mask
// - context mask bits survive D3-to-D0 with wake enabled
// - state bit 0 shows status-change pin
// - bits 1,2 mirror detect pins, reset 1
// - bit 3 shows socket powered, reset clears
// - bits 4,5 record last card type
// - bit 6 follows card interrupt combinationally
// - bit 7 unsupported card blocks power
// - removal while active sets data-lost, read clears
// - bad supply request with cardbus card sets bit 9
// - voltage detect sets bits 10 to 13; detection here sets only bits 10 and 11, bits 12 and 13 only by force
// - bits 31:28 system supplies, default 3.3/5
// - force register holds no state
// - force 3:0 sets event latches only
// - force 4,5,7 sets type flags, no card
// - force 8,9 sets data-lost, bad request
// - force voltage bits blocks power until retest
// - force 14 or insertion runs retest
// - event latch bits clear on write one
module csr_socket_status
  import csr_pkg::*;
#(
  parameter logic [3:0] SYS_VOLTS = csr_pkg::SYSV_RESET
)(
  // system
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      seg_reset,
  input  wire logic                      wake_enable,
  // avalon-mm slave
  input  wire logic [csr_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  // socket pins
  input  wire logic                      pin_stschg,
  input  wire logic                      pin_cd1,
  input  wire logic                      pin_cd2,
  input  wire logic                      pin_vs1,
  input  wire logic                      pin_vs2,
  input  wire logic                      pin_card_irq,
  // power control side
  input  wire logic                      power_request,
  input  wire logic [3:0]                supply_select,
  input  wire logic                      interface_active,
  output logic                           socket_power_on,
  output logic                           buffer_flush,
  // event and interrupt
  output logic                           sock_irq,
  output logic      [3:0]                event_latch
);
  import csr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] sync_a_ff [5];
  logic [4:0] pin_s;
  logic [4:0] pin_raw;
  assign pin_raw = {pin_vs2, pin_vs1, pin_cd2, pin_cd1, pin_stschg};

  // two-stage synchronisers, first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        if (reset)
          sync_a_ff[gi] <= 2'b11;
        else
          sync_a_ff[gi] <= {sync_a_ff[gi][0], pin_raw[gi]};
      end
      assign pin_s[gi] = sync_a_ff[gi][1];
    end
  endgenerate

  logic stschg_s, cd1_s, cd2_s, vs1_s, vs2_s;
  assign stschg_s = ~pin_s[0];
  assign cd1_s    = pin_s[1];
  assign cd2_s    = pin_s[2];
  assign vs1_s    = pin_s[3];
  assign vs2_s    = pin_s[4];

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge
  csr_bus_e bus_ff;
  logic     access;
  logic     wr_go;
  logic     rd_go;
  assign access = avs_read | avs_write;
  assign wr_go  = avs_write & (bus_ff == CSR_ACK);
  assign rd_go  = avs_read & (bus_ff == CSR_ACK);
  assign avs_waitrequest = access & (bus_ff != CSR_ACK);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      bus_ff <= CSR_IDLE;
    else if (bus_ff == CSR_ACK)
      bus_ff <= CSR_IDLE;
    else if (access)
      bus_ff <= CSR_ACK;
  end

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  logic [31:0] wdat;
  assign wdat = avs_writedata & be_mask(avs_byteenable);

  logic wr_event, wr_mask, wr_force, rd_state;
  assign wr_event = wr_go & (avs_address == OFS_EVENT);
  assign wr_mask  = wr_go & (avs_address == OFS_MASK);
  assign wr_force = wr_go & (avs_address == OFS_FORCE);
  assign rd_state = rd_go & (avs_address == OFS_STATE);

  logic [31:0] force_p;
  assign force_p = wr_force ? wdat : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // card detect and type
  logic cd1_d_ff, cd2_d_ff;
  logic card_in, inserted, removed;
  assign card_in = ~cd1_s & ~cd2_s;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cd1_d_ff <= 1'b1;
      cd2_d_ff <= 1'b1;
    end
    else
    begin
      cd1_d_ff <= cd1_s;
      cd2_d_ff <= cd2_s;
    end
  end

  logic cd1_chg, cd2_chg, was_in;
  assign cd1_chg  = cd1_s ^ cd1_d_ff;
  assign cd2_chg  = cd2_s ^ cd2_d_ff;
  assign was_in   = ~cd1_d_ff & ~cd2_d_ff;
  assign inserted = card_in & ~was_in;
  assign removed  = ~card_in & was_in;

  logic retest_ff;
  logic c16_ff, cbus_ff, notcard_ff;
  logic [3:0] cardv_ff;
  logic v_lock_ff;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      retest_ff <= 1'b0;
    else
      retest_ff <= inserted | force_p[B_RETEST];
  end

  // type decoded from detect and sense pins
  logic is16, iscb, isbad;
  assign is16  = card_in & vs1_s & vs2_s;
  assign iscb  = card_in & ~vs1_s & vs2_s;
  assign isbad = card_in & ~is16 & ~iscb;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      c16_ff     <= 1'b0;
      cbus_ff    <= 1'b0;
      notcard_ff <= 1'b0;
    end
    else if (retest_ff)
    begin
      c16_ff     <= is16;
      cbus_ff    <= iscb;
      notcard_ff <= isbad;
    end
    else if (!card_in)
    begin
      c16_ff     <= c16_ff | force_p[B_C16];
      cbus_ff    <= cbus_ff | force_p[B_CBUS];
      notcard_ff <= notcard_ff | force_p[B_NOTCARD];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cardv_ff  <= 4'h0;
      v_lock_ff <= 1'b0;
    end
    else if (retest_ff)
    begin
      cardv_ff  <= {1'b0, 1'b0, iscb | is16, is16 | (iscb & vs1_s)};
      v_lock_ff <= 1'b0;
    end
    else if (|force_p[B_CV_LO +: 4])
    begin
      cardv_ff  <= cardv_ff | force_p[B_CV_LO +: 4];
      v_lock_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power sequencing
  csr_pwr_e   pwr_ff;
  logic [8:0] pwr_cnt_ff;
  logic       pwr_done_p;
  logic       bad_req, pwr_allowed;
  assign bad_req     = power_request & (|(supply_select & ~(cardv_ff & SYS_VOLTS)));
  assign pwr_allowed = power_request & card_in & ~notcard_ff & ~v_lock_ff & ~bad_req;
  assign pwr_done_p  = (pwr_ff == CSR_P_WAIT) && (pwr_cnt_ff == 9'(PWR_DONE_CYC - 1));

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pwr_ff     <= CSR_P_OFF;
      pwr_cnt_ff <= 9'h000;
    end
    else if (!pwr_allowed)
    begin
      pwr_ff     <= CSR_P_OFF;
      pwr_cnt_ff <= 9'h000;
    end
    else
    begin
      case (pwr_ff)
        CSR_P_OFF:
        begin
          pwr_ff     <= CSR_P_RAMP;
          pwr_cnt_ff <= 9'h000;
        end
        CSR_P_RAMP:
        begin
          pwr_cnt_ff <= pwr_cnt_ff + 9'h001;
          if (pwr_cnt_ff == 9'(PWR_UP_CYC - 1))
          begin
            pwr_ff     <= CSR_P_WAIT;
            pwr_cnt_ff <= 9'h000;
          end
        end
        CSR_P_WAIT:
        begin
          pwr_cnt_ff <= pwr_cnt_ff + 9'h001;
          if (pwr_done_p)
            pwr_ff <= CSR_P_ON;
        end
        CSR_P_ON: pwr_ff <= CSR_P_ON;
        default:  pwr_ff <= CSR_P_OFF;
      endcase
    end
  end

  assign socket_power_on = (pwr_ff == CSR_P_WAIT) || (pwr_ff == CSR_P_ON);

  ////////////////////////////////////////////////////////////////////////
  // sticky flags
  logic dlost_ff, badv_ff;
  // removal while active, clear on read; set wins
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      dlost_ff <= 1'b0;
      badv_ff  <= 1'b0;
    end
    else
    begin
      if ((removed & interface_active) | force_p[B_DLOST])
        dlost_ff <= 1'b1;
      else if (rd_state)
        dlost_ff <= 1'b0;
      if ((bad_req & cbus_ff) | force_p[B_BADV])
        badv_ff <= 1'b1;
    end
  end
  assign buffer_flush = removed & interface_active;

  ////////////////////////////////////////////////////////////////////////
  // event latch and mask
  logic [3:0] mask_ff;
  logic [3:0] ev_set;
  logic       stschg_d_ff;
  logic       ctx_hold;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      stschg_d_ff <= 1'b0;
    else
      stschg_d_ff <= stschg_s;
  end

  assign ev_set = {pwr_done_p,
                   cd2_chg,
                   cd1_chg,
                   stschg_s & ~stschg_d_ff & (pwr_ff != CSR_P_WAIT)} | force_p[3:0];

  assign ctx_hold = seg_reset & wake_enable;

  always_ff @(posedge clk_sys)
  begin
    if (reset | (seg_reset & ~ctx_hold))
      mask_ff <= 4'h0;
    else if (removed)
      mask_ff <= 4'h0;
    else if (wr_mask)
      mask_ff <= wdat[3:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset | (seg_reset & ~ctx_hold))
      event_latch <= 4'h0;
    else
      event_latch <= ev_set | (event_latch & ~(wr_event ? wdat[3:0] : 4'h0));
  end

  // removal irq outlives the mask clear, until detect events are cleared
  logic rm_irq_ff;
  always_ff @(posedge clk_sys)
  begin
    if (reset | (seg_reset & ~ctx_hold))
      rm_irq_ff <= 1'b0;
    else if (removed & (|mask_ff[2:1]))
      rm_irq_ff <= 1'b1;
    else if (~|event_latch[2:1])
      rm_irq_ff <= 1'b0;
  end

  assign sock_irq = (|(event_latch & mask_ff)) | rm_irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] state_word;
  assign state_word = {SYS_VOLTS, 14'h0000, cardv_ff, badv_ff, dlost_ff, notcard_ff,
                       pin_card_irq, cbus_ff, c16_ff, socket_power_on, cd2_s, cd1_s,
                       stschg_s};

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & (bus_ff == CSR_IDLE))
    begin
      case (avs_address)
        OFS_EVENT: avs_readdata <= {28'h000_0000, event_latch & EVENT_USED};
        OFS_MASK:  avs_readdata <= {28'h000_0000, mask_ff};
        OFS_STATE: avs_readdata <= state_word;
        default:   avs_readdata <= RD_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (reset)
    sock_irq |-> (|(event_latch & mask_ff)) || rm_irq_ff)
    else $error("irq without masked event");
  a_removal_irq: assert property (@(posedge clk_sys) disable iff (reset || seg_reset)
    removed && (|mask_ff[2:1]) |=> sock_irq)
    else $error("no interrupt on removal");
  a_mask_clear: assert property (@(posedge clk_sys) disable iff (reset)
    removed |=> mask_ff == 4'h0)
    else $error("mask not cleared on removal");
  sequence s_wait_start;
    (pwr_ff == CSR_P_RAMP) ##1 (pwr_ff == CSR_P_WAIT);
  endsequence
  a_pwr_delay: assert property (@(posedge clk_sys) disable iff (reset)
    s_wait_start |-> (pwr_allowed && !pwr_done_p) [*1] ##0 1)
    else $error("power complete too early");
  a_no_power_bad: assert property (@(posedge clk_sys) disable iff (reset)
    notcard_ff |=> pwr_ff == CSR_P_OFF)
    else $error("power with unsupported card");
  a_lock_power: assert property (@(posedge clk_sys) disable iff (reset)
    v_lock_ff |=> !socket_power_on)
    else $error("power while voltage locked");
  a_dlost_rc: assert property (@(posedge clk_sys) disable iff (reset)
    rd_state && !buffer_flush && !force_p[B_DLOST] |=> !dlost_ff)
    else $error("data lost not cleared by read");
  a_force_ev: assert property (@(posedge clk_sys) disable iff (reset || seg_reset)
    wr_force && wdat[0] |=> event_latch[0])
    else $error("forced event not latched");
  a_type_ignored: assert property (@(posedge clk_sys) disable iff (reset)
    wr_force && card_in && !retest_ff && !c16_ff |=> !c16_ff)
    else $error("type force with card present");
  a_irq_follow: assert property (@(posedge clk_sys) disable iff (reset)
    avs_read && avs_address == OFS_STATE && bus_ff == CSR_IDLE
      |=> avs_readdata[B_CINT] == $past(pin_card_irq))
    else $error("interrupt bit not live");
endmodule // csr_socket_status
`default_nettype wire

// ==== test/csr_card_model.sv ====
/*
  card model for the socket: drives detect, voltage sense, status change
  and interrupt pins of one inserted card.
  assumes host-side pull-ups hold every card line inactive when empty.
*/
`timescale 1ns/10ps
`default_nettype none
module csr_card_model (
  // bench control
  input  wire logic present,
  input  wire logic cardbus,
  input  wire logic stschg_on,
  input  wire logic irq_on,
  // socket pins
  output logic      pin_cd1,
  output logic      pin_cd2,
  output logic      pin_vs1,
  output logic      pin_vs2,
  output logic      pin_stschg,
  output logic      pin_card_irq
);
  // empty socket: pull-ups win, so detect and sense lines read high
  assign pin_cd1      = !present;
  assign pin_cd2      = !present;
  assign pin_vs1      = present ? !cardbus : 1'b1;
  assign pin_vs2      = 1'b1;
  assign pin_stschg   = !(present && stschg_on);
  assign pin_card_irq = present && irq_on;
endmodule // csr_card_model
`default_nettype wire

// ==== test/test_cardbus_socket_status_regs.sv ====
/*
  self-checking bench for the socket status register bank.
  assumes the card model above and a one-wait-state avalon slave.
*/
`timescale 1ns/10ps
`default_nettype none
module test_cardbus_socket_status_regs;
  import csr_pkg::*;
  typedef struct packed {logic we; logic [3:0] a; logic [31:0] d;} csr_row_s;
  localparam logic [31:0] IDLE_ST = 32'h3000_0006;
  localparam logic [3:0]  SYS_VOLTS_DEF = SYSV_RESET;
  logic        clk_sys = 1'b0, reset = 1'b1, seg_reset = 1'b0, wake_enable = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf, supply_select = 4'h0;
  logic        avs_read = 1'b0, avs_write = 1'b0, power_request = 1'b0;
  logic        interface_active = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        present = 1'b0, cardbus = 1'b0, stschg_on = 1'b0, irq_on = 1'b0;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, socket_power_on, buffer_flush, sock_irq;
  logic [3:0]  event_latch, sel;
  logic        pin_cd1, pin_cd2, pin_vs1, pin_vs2, pin_stschg, pin_card_irq;
  int          error_cnt = 0, comparisons = 0, n;
  int          fb [5] = '{4, 5, 7, 8, 9};
  csr_row_s    rows [10];

  always #4 clk_sys = ~clk_sys;

  csr_socket_status uut (
    .clk_sys(clk_sys), .reset(reset), .seg_reset(seg_reset), .wake_enable(wake_enable),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_stschg(pin_stschg), .pin_cd1(pin_cd1), .pin_cd2(pin_cd2), .pin_vs1(pin_vs1),
    .pin_vs2(pin_vs2), .pin_card_irq(pin_card_irq), .power_request(power_request),
    .supply_select(supply_select), .interface_active(interface_active),
    .socket_power_on(socket_power_on), .buffer_flush(buffer_flush),
    .sock_irq(sock_irq), .event_latch(event_latch)
  );

  csr_card_model card (
    .present(present), .cardbus(cardbus), .stschg_on(stschg_on), .irq_on(irq_on),
    .pin_cd1(pin_cd1), .pin_cd2(pin_cd2), .pin_vs1(pin_vs1), .pin_vs2(pin_vs2),
    .pin_stschg(pin_stschg), .pin_card_irq(pin_card_irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  task results;
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waitrequest and read data are taken at the rising edge, before it updates
  task bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_read      <= !we;
    avs_write     <= we;
    avs_writedata <= wd;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50)
    begin
      error_cnt++;
      results();
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  // power asked for 300 cycles must never reach the socket
  task no_power;
    int h;
    h = 0;
    @(posedge clk_sys);
    power_request <= 1'b1;
    supply_select <= 4'h1;
    repeat (300) begin
      @(negedge clk_sys);
      h += (socket_power_on === 1'b1);
    end
    @(posedge clk_sys);
    power_request <= 1'b0;
    chk(32'(h), 32'h0000_0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = '{1'b0, OFS_EVENT, 32'h0000_0000};
    rows[1] = '{1'b0, OFS_MASK, 32'h0000_0000};
    rows[2] = '{1'b0, OFS_STATE, IDLE_ST};
    rows[3] = '{1'b0, OFS_FORCE, 32'h0000_0000};
    rows[4] = '{1'b1, OFS_MASK, 32'hffff_ffff};
    rows[5] = '{1'b0, OFS_MASK, 32'h0000_000f};
    rows[6] = '{1'b1, OFS_STATE, 32'hffff_ffff};
    rows[7] = '{1'b0, OFS_STATE, IDLE_ST};
    rows[8] = '{1'b0, 4'h2, 32'h0000_0000};
    rows[9] = '{1'b1, OFS_MASK, 32'h0000_0005};
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    cyc(4);
    foreach (rows[i])
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      else rchk(rows[i].a, rows[i].d);
    // forced events with mask 0101: only even bits interrupt
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_FORCE, 32'h0000_0001 << i);
      cyc(2);
      chk({28'h0, event_latch}, 32'h0000_0001 << i);
      chk({31'h0, sock_irq}, {31'h0, ~i[0]});
      rchk(OFS_STATE, IDLE_ST);
      wr(OFS_EVENT, 32'h0000_0001 << i);
      cyc(2);
      chk({28'h0, event_latch}, 32'h0000_0000);
    end
    wr(OFS_MASK, 32'h0000_0009);
    wake_enable <= 1'b1;
    seg_reset   <= 1'b1;
    @(posedge clk_sys);
    seg_reset <= 1'b0;
    rchk(OFS_MASK, 32'h0000_0009);
    wake_enable <= 1'b0;
    seg_reset   <= 1'b1;
    @(posedge clk_sys);
    seg_reset <= 1'b0;
    rchk(OFS_MASK, 32'h0000_0000);
    foreach (fb[i])
    begin
      wr(OFS_FORCE, 32'h0000_0001 << fb[i]);
      bus(1'b0, OFS_STATE, 32'h0000_0000);
      chk(rd & (32'h0000_0001 << fb[i]), 32'h0000_0001 << fb[i]);
    end
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    chk({31'h0, rd[B_DLOST]}, 32'h0000_0000);
    no_power();
    // cardbus card goes in: detect, type and change events
    present <= 1'b1;
    cardbus <= 1'b1;
    cyc(8);
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    chk({27'h0, rd[5:1]}, 32'h0000_0010);
    chk({28'h0, event_latch}, 32'h0000_0006);
    wr(OFS_FORCE, 32'h0000_0010);
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    chk({31'h0, rd[B_C16]}, 32'h0000_0000);
    stschg_on <= 1'b1;
    irq_on    <= 1'b1;
    cyc(4);
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    chk({30'h0, rd[B_CINT], rd[B_STSCHG]}, 32'h0000_0003);
    stschg_on <= 1'b0;
    irq_on    <= 1'b0;
    wr(OFS_FORCE, 32'h0000_0400);
    no_power();
    wr(OFS_FORCE, 32'h0000_4000);
    cyc(4);
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    sel = rd[13:10] & SYS_VOLTS_DEF;
    sel = sel & (~sel + 4'h1);
    chk({31'h0, sel != 4'h0}, 32'h0000_0001);
    wr(OFS_MASK, 32'h0000_0008);
    wr(OFS_EVENT, 32'h0000_000f);
    power_request    <= 1'b1;
    supply_select    <= sel;
    interface_active <= 1'b1;
    n = 0;
    while (socket_power_on !== 1'b1 && n < 400) begin cyc(1); n++; end
    n = 0;
    while (event_latch[3] !== 1'b1 && n < 400) begin cyc(1); n++; end
    chk(32'(n >= PWR_DONE_CYC && n <= PWR_DONE_CYC + 1), 32'h0000_0001);
    chk({31'h0, sock_irq}, 32'h0000_0001);
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    chk({31'h0, rd[B_PWR]}, 32'h0000_0001);
    // pull the card while the interface is busy
    wr(OFS_MASK, 32'h0000_0002);
    present <= 1'b0;
    n = 0;
    while (buffer_flush !== 1'b1 && n < 20) begin cyc(1); n++; end
    chk(32'(n < 20), 32'h0000_0001);
    cyc(1);
    chk({31'h0, sock_irq}, 32'h0000_0001);
    cyc(4);
    rchk(OFS_MASK, 32'h0000_0000);
    bus(1'b0, OFS_STATE, 32'h0000_0000);
    chk({31'h0, rd[B_DLOST]}, 32'h0000_0001);
    power_request    <= 1'b0;
    interface_active <= 1'b0;
    reset            <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    cyc(4);
    rchk(OFS_STATE, IDLE_ST);
    rchk(OFS_EVENT, 32'h0000_0000);
    results();
  end
endmodule // test_cardbus_socket_status_regs
`default_nettype wire
